// ==== hdl/ims_params.svh ====
`ifndef IMS_PARAMS_SVH
`define IMS_PARAMS_SVH
// How it works
// - absolute travel is distance minus present position
// - relative travel is the distance itself
// - velocity is magnitude, direction from travel sign
// - short travel gives a triangular profile
// - separate accel and decel ramps per index
// - registration trigger switches to registration distance, velocity
// - registration ramps reuse the index accel, decel
// - repeat count reruns motion without dwell
// - dwell in milliseconds after the profile
// - action stop ends the whole sequence
// - start after stop uses the start index
// - action wait holds until start
// - after wait, next index from index_select
// - action next runs the next-index field
// - eleven index types selectable per index
// - registration types begin as absolute or relative
// - sequence end raised after action stop or wait, not on a stop input
// - pause edge halts, next edge resumes
`define IMS_CLK_PERIOD_NS 10
`define IMS_TICK_TIME_MS 1
`define IMS_TICK_CYCLES ((`IMS_TICK_TIME_MS * 1000000) / `IMS_CLK_PERIOD_NS)
`define IMS_MICRO 64'h00000000000f4240
`define IMS_MILLI 48'h0000000003e8
`define IMS_OFS_START 12'h000
`define IMS_OFS_STATUS 12'h004
`define IMS_OFS_POS 12'h008
`define IMS_OFS_SPEED 12'h00c
`define IMS_TABLE_BIT 11
`define IMS_W_DIST 3'h0
`define IMS_W_VEL 3'h1
`define IMS_W_ACC 3'h2
`define IMS_W_DEC 3'h3
`define IMS_W_RDIST 3'h4
`define IMS_W_RVEL 3'h5
`define IMS_W_REPDW 3'h6
`define IMS_W_CTRL 3'h7
`define IMS_REP_LSB 16
`define IMS_DWELL_LSB 0
`define IMS_ACT_LSB 0
`define IMS_NEXT_LSB 8
`define IMS_TYPE_LSB 16
`define IMS_START_RST 6'h00
`endif

// ==== hdl/ims_pkg.sv ====
package ims_pkg;
	typedef enum logic [2:0] {
		IMS_IDLE  = 3'h0,
		IMS_LOAD  = 3'h1,
		IMS_RUN   = 3'h3,
		IMS_DWELL = 3'h2,
		IMS_WAIT  = 3'h6
	} ims_state_e;

	typedef enum logic [1:0] {
		IMS_ACT_STOP = 2'h0,
		IMS_ACT_WAIT = 2'h1,
		IMS_ACT_NEXT = 2'h2
	} ims_action_e;

	typedef enum logic [3:0] {
		IMS_T_ABS     = 4'h0,
		IMS_T_REL     = 4'h1,
		IMS_T_BLD_ABS = 4'h2,
		IMS_T_BLD_REL = 4'h3,
		IMS_T_ROT_ABS = 4'h4,
		IMS_T_ROT_REL = 4'h5,
		IMS_T_ROT_SH  = 4'h6,
		IMS_T_ROT_POS = 4'h7,
		IMS_T_ROT_NEG = 4'h8,
		IMS_T_REG_ABS = 4'h9,
		IMS_T_REG_REL = 4'ha
	} ims_type_e;

	typedef struct packed {
		ims_state_e         st;
		logic               ack;
		logic [31:0]        rdat;
		logic [5:0]         startIdx;
		logic [5:0]         idx;
		logic               paused;
		logic               seqEnd;
		logic               trigUsed;
		logic               dir;
		logic [63:0]        rem;
		logic [47:0]        vel;
		logic [47:0]        tgt;
		logic signed [63:0] pos;
		logic [31:0]        posUu;
		logic [15:0]        rep;
		logic [15:0]        dwell;
		logic [31:0]        tick;
		logic               pStart;
		logic               pPause;
		logic               pTrig;
		logic               pStop;
	} ims_regs_s;
endpackage : ims_pkg

// ==== hdl/ims_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ims_params.svh"
module ims_sequencer
#(
	parameter int TICK_CYCLES = `IMS_TICK_CYCLES
)
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        startIn,
	input  wire logic        stopIn,
	input  wire logic        pauseIn,
	input  wire logic        registrationTrigger,
	input  wire logic [5:0]  indexSelect,
	output logic             sequenceEndFlag,
	output logic      [5:0]  currentIndex,
	output logic             busy,
	output logic             pausedOut,
	output logic             moveDir,
	output logic      [47:0] speedMilli,
	output logic      [31:0] positionUu
);
	ims_pkg::ims_regs_s r_reg;
	ims_pkg::ims_regs_s r_next;
	// 8 words per entry, 64 entries
	logic [31:0] table_reg [0:511];

	logic               wbHit;
	logic               startEdge;
	logic               pauseEdge;
	logic               trigEdge;
	logic               stopEdge;
	logic               tickNow;
	logic [31:0]        eDist;
	logic [31:0]        eVel;
	logic [31:0]        eAcc;
	logic [31:0]        eDec;
	logic [31:0]        eRDist;
	logic [31:0]        eRVel;
	logic [15:0]        eRep;
	logic [15:0]        eDwell;
	logic [1:0]         eAct;
	logic [5:0]         eNext;
	logic [3:0]         eType;
	logic               isAbs;
	logic               isReg;
	logic signed [32:0] travel;
	logic [111:0]       need;
	logic [111:0]       vsq;
	logic               brake;
	logic [47:0]        accM;
	logic [47:0]        decM;
	logic [47:0]        nv;

	function automatic logic [8:0] slot(input logic [5:0] i, input logic [2:0] w);
		slot = {i, w};
	endfunction : slot

	// magnitude of a signed uu value, scaled to micro-uu
	function automatic logic [63:0] toMicro(input logic signed [32:0] v);
		logic [32:0] m;
		m = v[32] ? 33'(-v) : 33'(v);
		toMicro = 64'(m) * `IMS_MICRO;
	endfunction : toMicro

	// uu/s to milli-uu/s, used for index and registration speeds
	function automatic logic [47:0] toMilli(input logic [31:0] v);
		toMilli = 48'(v) * `IMS_MILLI;
	endfunction : toMilli

	// one step along the travel direction
	function automatic logic signed [63:0] stepPos(input logic signed [63:0] p, input logic d,
		input logic [63:0] s);
		stepPos = d ? p - $signed(s) : p + $signed(s);
	endfunction : stepPos

	always_ff @(posedge ref_clk)
	begin
		if (wb_cyc_i & wb_stb_i & ~r_reg.ack & wb_we_i & wb_adr_i[`IMS_TABLE_BIT])
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wb_sel_i[b])
				begin
					table_reg[wb_adr_i[10:2]][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	always_comb
	begin
		r_next = r_reg;
		wbHit = wb_cyc_i & wb_stb_i & ~r_reg.ack;
		startEdge = startIn & ~r_reg.pStart;
		pauseEdge = pauseIn & ~r_reg.pPause;
		trigEdge = registrationTrigger & ~r_reg.pTrig;
		stopEdge = stopIn & ~r_reg.pStop;
		tickNow = (r_reg.tick == 32'(TICK_CYCLES - 1));
		eDist = table_reg[slot(r_reg.idx, `IMS_W_DIST)];
		eVel = table_reg[slot(r_reg.idx, `IMS_W_VEL)];
		eAcc = table_reg[slot(r_reg.idx, `IMS_W_ACC)];
		eDec = table_reg[slot(r_reg.idx, `IMS_W_DEC)];
		eRDist = table_reg[slot(r_reg.idx, `IMS_W_RDIST)];
		eRVel = table_reg[slot(r_reg.idx, `IMS_W_RVEL)];
		eRep = table_reg[slot(r_reg.idx, `IMS_W_REPDW)][`IMS_REP_LSB +: 16];
		eDwell = table_reg[slot(r_reg.idx, `IMS_W_REPDW)][`IMS_DWELL_LSB +: 16];
		eAct = table_reg[slot(r_reg.idx, `IMS_W_CTRL)][`IMS_ACT_LSB +: 2];
		eNext = table_reg[slot(r_reg.idx, `IMS_W_CTRL)][`IMS_NEXT_LSB +: 6];
		eType = table_reg[slot(r_reg.idx, `IMS_W_CTRL)][`IMS_TYPE_LSB +: 4];
		// blending and rotary types run as plain linear moves here
		case (eType)
			ims_pkg::IMS_T_ABS,
			ims_pkg::IMS_T_BLD_ABS,
			ims_pkg::IMS_T_ROT_ABS,
			ims_pkg::IMS_T_ROT_SH,
			ims_pkg::IMS_T_REG_ABS: isAbs = 1'b1;
			default: isAbs = 1'b0;
		endcase
		isReg = (eType == ims_pkg::IMS_T_REG_ABS) | (eType == ims_pkg::IMS_T_REG_REL);
		if (isAbs)
		begin
			travel = $signed({eDist[31], eDist}) - $signed({r_reg.posUu[31], r_reg.posUu});
		end
		else
		begin
			travel = $signed({eDist[31], eDist});
		end
		accM = 48'(eAcc);
		decM = 48'(eDec);
		need = 112'h0;
		vsq = 112'h0;
		brake = 1'b0;
		nv = r_reg.vel;

		r_next.pStart = startIn;
		r_next.pPause = pauseIn;
		r_next.pTrig = registrationTrigger;
		r_next.pStop = stopIn;
		r_next.tick = tickNow ? 32'h0 : r_reg.tick + 32'h1;

		r_next.ack = wbHit;
		r_next.rdat = 32'h0;
		if (wbHit & wb_we_i & (wb_adr_i == `IMS_OFS_START) & wb_sel_i[0])
		begin
			r_next.startIdx = wb_dat_i[5:0];
		end
		if (wbHit & ~wb_we_i)
		begin
			if (wb_adr_i[`IMS_TABLE_BIT])
			begin
				r_next.rdat = table_reg[wb_adr_i[10:2]];
			end
			else
			begin
				case (wb_adr_i)
					`IMS_OFS_START: r_next.rdat = {26'h0, r_reg.startIdx};
					`IMS_OFS_STATUS: r_next.rdat = {18'h0, r_reg.idx, r_reg.dir,
						r_reg.paused, r_reg.seqEnd, 2'h0, r_reg.st};
					`IMS_OFS_POS: r_next.rdat = r_reg.posUu;
					`IMS_OFS_SPEED: r_next.rdat = r_reg.vel[31:0];
					default: r_next.rdat = 32'h0;
				endcase
			end
		end

		case (r_reg.st)
			ims_pkg::IMS_IDLE:
			begin
				if (startEdge)
				begin
					r_next.idx = r_reg.startIdx;
					r_next.seqEnd = 1'b0;
					r_next.rep = 16'h0;
					r_next.st = ims_pkg::IMS_LOAD;
				end
			end
			ims_pkg::IMS_LOAD:
			begin
				if (r_reg.rep == 16'h0)
				begin
					r_next.rep = (eRep == 16'h0) ? 16'h1 : eRep;
				end
				r_next.dir = travel[32];
				r_next.rem = toMicro(travel);
				r_next.tgt = toMilli(eVel);
				r_next.trigUsed = 1'b0;
				r_next.paused = 1'b0;
				r_next.st = ims_pkg::IMS_RUN;
			end
			ims_pkg::IMS_RUN:
			begin
				if ((r_reg.rem == 64'h0) & (r_reg.vel == 48'h0))
				begin
					if (r_reg.rep > 16'h1)
					begin
						// repeats go straight back, no dwell
						r_next.rep = r_reg.rep - 16'h1;
						r_next.st = ims_pkg::IMS_LOAD;
					end
					else
					begin
						r_next.dwell = eDwell;
						r_next.st = ims_pkg::IMS_DWELL;
					end
				end
				else
				begin
					if (pauseEdge)
					begin
						r_next.paused = ~r_reg.paused;
					end
					if (trigEdge & isReg & ~r_reg.trigUsed)
					begin
						r_next.rem = toMicro($signed({eRDist[31], eRDist}));
						r_next.tgt = toMilli(eRVel);
						r_next.trigUsed = 1'b1;
					end
					if (tickNow)
					begin
						// brake once stopping distance reaches the remainder
						need = 112'(r_next.rem) * 112'({eDec, 1'b0});
						vsq = 112'(r_reg.vel) * 112'(r_reg.vel);
						brake = need <= vsq;
						if (r_reg.paused)
						begin
							nv = (r_reg.vel > decM) ? r_reg.vel - decM : 48'h0;
						end
						else if (brake)
						begin
							// crawl floor avoids stalling short of target
							nv = (r_reg.vel > decM) ? r_reg.vel - decM : (decM | 48'h1);
						end
						else if (r_reg.vel < r_next.tgt)
						begin
							nv = ((r_next.tgt - r_reg.vel) > accM) ? r_reg.vel + accM
								: r_next.tgt;
						end
						else
						begin
							nv = ((r_reg.vel - r_next.tgt) > decM) ? r_reg.vel - decM
								: r_next.tgt;
						end
						if (64'(nv) >= r_next.rem)
						begin
							r_next.pos = stepPos(r_reg.pos, r_reg.dir, r_next.rem);
							r_next.rem = 64'h0;
							r_next.vel = 48'h0;
						end
						else
						begin
							r_next.rem = r_next.rem - 64'(nv);
							r_next.pos = stepPos(r_reg.pos, r_reg.dir, 64'(nv));
							r_next.vel = nv;
						end
					end
				end
			end
			ims_pkg::IMS_DWELL:
			begin
				if (r_reg.dwell != 16'h0)
				begin
					if (tickNow)
					begin
						r_next.dwell = r_reg.dwell - 16'h1;
					end
				end
				else
				begin
					case (eAct)
						ims_pkg::IMS_ACT_WAIT:
						begin
							r_next.seqEnd = 1'b1;
							r_next.st = ims_pkg::IMS_WAIT;
						end
						ims_pkg::IMS_ACT_NEXT:
						begin
							r_next.idx = eNext;
							r_next.rep = 16'h0;
							r_next.st = ims_pkg::IMS_LOAD;
						end
						default:
						begin
							// unused code 3 behaves as stop
							r_next.seqEnd = 1'b1;
							r_next.st = ims_pkg::IMS_IDLE;
						end
					endcase
				end
			end
			ims_pkg::IMS_WAIT:
			begin
				if (startEdge)
				begin
					r_next.idx = indexSelect;
					r_next.seqEnd = 1'b0;
					r_next.rep = 16'h0;
					r_next.st = ims_pkg::IMS_LOAD;
				end
			end
			default: r_next.st = ims_pkg::IMS_IDLE;
		endcase

		// stop aborts at once, no ramp
		if (stopEdge & (r_reg.st != ims_pkg::IMS_IDLE))
		begin
			r_next.st = ims_pkg::IMS_IDLE;
			r_next.vel = 48'h0;
			r_next.rem = 64'h0;
			r_next.paused = 1'b0;
		end
		r_next.posUu = 32'(r_next.pos / $signed(`IMS_MICRO));
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			r_reg <= '0;
			r_reg.st <= ims_pkg::IMS_IDLE;
			r_reg.startIdx <= `IMS_START_RST;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign wb_ack_o = r_reg.ack;
	assign wb_dat_o = r_reg.rdat;
	assign sequenceEndFlag = r_reg.seqEnd;
	assign currentIndex = r_reg.idx;
	assign busy = (r_reg.st != ims_pkg::IMS_IDLE) & (r_reg.st != ims_pkg::IMS_WAIT);
	assign pausedOut = r_reg.paused;
	assign moveDir = r_reg.dir;
	assign speedMilli = r_reg.vel;
	assign positionUu = r_reg.posUu;
endmodule : ims_sequencer
`default_nettype wire

// ==== tb/ims_sequencer_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ims_sequencer_chk
#(
	parameter int TICK_CYCLES = 10
)
(
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        startIn,
	input wire logic        stopIn,
	input wire logic        pauseIn,
	input wire logic        registrationTrigger,
	input wire logic [5:0]  indexSelect,
	input wire logic        sequenceEndFlag,
	input wire logic [5:0]  currentIndex,
	input wire logic        busy,
	input wire logic        pausedOut,
	input wire logic        moveDir,
	input wire logic [47:0] speedMilli,
	input wire logic [31:0] positionUu
);
	// pace check only holds when a tick outlasts the 8-cycle window
	localparam bit PaceOk = TICK_CYCLES > 8;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	sequence idle2;
		!busy ##1 !busy;
	endsequence
	sequence take;
		$rose(startIn) && !busy;
	endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	end_flag_a: assert property ($rose(sequenceEndFlag) |-> $fell(busy))
		else $error("end flag early");
	start_go_a: assert property (take |-> ##[1:2] busy) else $error("start lost");
	start_clr_a: assert property (take |-> ##[1:2] !sequenceEndFlag)
		else $error("end flag kept");
	pos_idle_a: assert property (idle2 |-> $stable(positionUu)) else $error("idle move");
	spd_idle_a: assert property (idle2 |-> speedMilli == 48'h0) else $error("idle speed");
	dir_keep_a: assert property (speedMilli != 48'h0 && $past(speedMilli) != 48'h0
		|-> $stable(moveDir)) else $error("direction flip");
	pause_slow_a: assert property (pausedOut && $past(pausedOut)
		|-> speedMilli <= $past(speedMilli)) else $error("speed rose in pause");
	// a stop zeroes speed off the tick, but busy is already low then
	tick_pace_a: assert property (PaceOk && busy && !$stable(speedMilli)
		|=> ($stable(speedMilli) || !busy) [*8]) else $error("ramp off tick");
endmodule : ims_sequencer_chk
bind ims_sequencer ims_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== tb/ims_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ims_ctrl_model
(
	input wire logic       ref_clk,
	input wire logic [3:0] req,
	input wire logic [5:0] selReq,
	output logic           startIn,
	output logic           stopIn,
	output logic           pauseIn,
	output logic           registrationTrigger,
	output logic [5:0]     indexSelect
);
	// two-cycle level per request, so each gives exactly one rising edge
	logic [3:0] lvlA = 4'h0;
	logic [3:0] lvlB = 4'h0;
	logic [5:0] selHold = 6'h00;
	always_ff @(posedge ref_clk)
	begin
		lvlA <= req;
		lvlB <= lvlA;
		selHold <= selReq;
	end
	assign startIn = lvlA[0] | lvlB[0];
	assign stopIn = lvlA[1] | lvlB[1];
	assign pauseIn = lvlA[2] | lvlB[2];
	assign registrationTrigger = lvlA[3] | lvlB[3];
	assign indexSelect = selHold;
endmodule : ims_ctrl_model
`default_nettype wire

// ==== tb/ims_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ims_sequencer_tb;
	typedef struct packed {
		logic               f;
		logic [3:0]         ty;
		logic signed [31:0] d;
		logic signed [31:0] e;
	} ims_row_s;
	logic ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic startIn, stopIn, pauseIn, registrationTrigger;
	logic sequenceEndFlag, busy, pausedOut, moveDir, dirSeen;
	logic [11:0] wb_adr_i;
	logic [3:0] wb_sel_i, req;
	logic [31:0] wb_dat_i, wb_dat_o, positionUu;
	logic [5:0] indexSelect, currentIndex, selReq;
	logic [47:0] speedMilli, peak;
	logic signed [31:0] expPos;
	int error_cnt, tests_run;
	// f: travel long enough to reach full speed; e: expected position
	ims_row_s rows [11] = '{'{1'b1, 4'h0, 32'sh0a, 32'sh0a}, '{1'b0, 4'h1, -32'sh4, 32'sh6},
		'{1'b1, 4'h2, 32'sh14, 32'sh14}, '{1'b0, 4'h3, -32'sh5, 32'sh0f},
		'{1'b1, 4'h4, 32'sh3, 32'sh3}, '{1'b0, 4'h5, 32'sh7, 32'sh0a},
		'{1'b0, 4'h6, 32'sh0c, 32'sh0c}, '{1'b0, 4'h7, -32'sh2, 32'sh0a},
		'{1'b0, 4'h8, 32'sh4, 32'sh0e}, '{1'b1, 4'h9, 32'sh0, 32'sh0},
		'{1'b0, 4'ha, 32'sh5, 32'sh5}};
	ims_sequencer #(.TICK_CYCLES(10)) u_dut (.*);
	ims_ctrl_model u_ctrl (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic close_out;
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (wb_ack_o !== 1'b1)
		begin
			error_cnt++;
			close_out();
		end
	endtask : wb
	task automatic ent(input logic [5:0] i, input logic [3:0] ty, input logic [31:0] d,
		input logic [31:0] rd, input logic [31:0] rp, input logic [1:0] act,
		input logic [5:0] nx);
		logic [31:0] v [8];
		logic [31:0] q;
		v = '{d, 32'h3e8, 32'h186a0, 32'h186a0, rd, 32'h1f4, rp,
			{12'h0, ty, 2'h0, nx, 6'h0, act}};
		for (int w = 0; w < 8; w++)
			wb(1'b1, {1'b1, i, w[2:0], 2'h0}, v[w], q);
	endtask : ent
	task automatic pin(input logic [3:0] r);
		req <= r;
		@(posedge ref_clk);
		req <= 4'h0;
		repeat (4) @(posedge ref_clk);
	endtask : pin
	task automatic waitEnd(output int n);
		n = 0;
		peak = 48'h0;
		while (!(sequenceEndFlag === 1'b1 && busy === 1'b0) && n < 9000)
		begin
			@(posedge ref_clk);
			n++;
			if (speedMilli !== 48'h0)
				dirSeen = moveDir;
			if (speedMilli > peak)
				peak = speedMilli;
		end
		if (n >= 9000)
		begin
			error_cnt++;
			close_out();
		end
	endtask : waitEnd
	task automatic go(input logic [5:0] s, output int n);
		selReq <= s;
		pin(4'h1);
		waitEnd(n);
	endtask : go
	initial
	begin
		logic [31:0] q;
		logic signed [31:0] p;
		int n0, n1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		req = 4'h0;
		selReq = 6'h00;
		reset_n = 1'b0;
		dirSeen = 1'b0;
		expPos = '0;
		error_cnt = 0;
		tests_run = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		wb(1'b1, 12'h010, 32'hffffffff, q);
		wb(1'b0, 12'h010, 32'h0, q);
		chk(q, 32'h0);
		wb(1'b0, 12'h000, 32'h0, q);
		chk(q, 32'h0);
		for (int k = 0; k < 11; k++)
		begin
			ent(6'h00, rows[k].ty, rows[k].d, 32'h0, 32'h00010000, 2'h0, 6'h00);
			go(6'h00, n0);
			wb(1'b0, 12'h008, 32'h0, q);
			chk(q, rows[k].e);
			chk({31'h0, dirSeen}, {31'h0, rows[k].e < expPos});
			chk({31'h0, peak == 48'h0f4240}, {31'h0, rows[k].f});
			expPos = rows[k].e;
		end
		// same index with and without dwell; the gap is the dwell alone
		ent(6'h01, 4'h1, 32'sh2, 32'h0, 32'h00030000, 2'h0, 6'h00);
		wb(1'b1, 12'h000, 32'h1, q);
		go(6'h00, n0);
		ent(6'h01, 4'h1, 32'sh2, 32'h0, 32'h00030008, 2'h0, 6'h00);
		go(6'h00, n1);
		expPos += 32'sh0c;
		chk(positionUu, expPos);
		chk({26'h0, currentIndex}, 32'h1);
		chk({31'h0, (n1 - n0) inside {[32'sh3c:32'sh64]}}, 32'h1);
		ent(6'h02, 4'h1, 32'sh3, 32'h0, 32'h00010000, 2'h2, 6'h03);
		ent(6'h03, 4'h1, 32'sh4, 32'h0, 32'h00010000, 2'h0, 6'h00);
		wb(1'b1, 12'h000, 32'h2, q);
		go(6'h00, n0);
		expPos += 32'sh7;
		chk(positionUu, expPos);
		chk({26'h0, currentIndex}, 32'h3);
		ent(6'h04, 4'h1, 32'sh1, 32'h0, 32'h00010000, 2'h1, 6'h05);
		ent(6'h05, 4'h1, 32'sh64, 32'h0, 32'h00010000, 2'h0, 6'h00);
		ent(6'h06, 4'h1, 32'sh2, 32'h0, 32'h00010000, 2'h0, 6'h00);
		wb(1'b1, 12'h000, 32'h4, q);
		go(6'h00, n0);
		wb(1'b0, 12'h004, 32'h0, q);
		chk(q & 32'h27, 32'h26);
		go(6'h06, n0);
		expPos += 32'sh3;
		chk(positionUu, expPos);
		chk({26'h0, currentIndex}, 32'h6);
		// second trigger comes mid-move, so honouring it would overshoot
		ent(6'h07, 4'ha, 32'sh32, 32'h14, 32'h00010000, 2'h0, 6'h00);
		wb(1'b1, 12'h000, 32'h7, q);
		pin(4'h1);
		repeat (150) @(posedge ref_clk);
		pin(4'h8);
		p = positionUu;
		repeat (100) @(posedge ref_clk);
		pin(4'h8);
		waitEnd(n0);
		chk({31'h0, (positionUu - p) inside {[32'h13:32'h15]}}, 32'h1);
		ent(6'h08, 4'h1, 32'sh1e, 32'h0, 32'h00010000, 2'h0, 6'h00);
		wb(1'b1, 12'h000, 32'h8, q);
		p = positionUu;
		pin(4'h1);
		repeat (100) @(posedge ref_clk);
		pin(4'h4);
		repeat (300) @(posedge ref_clk);
		chk({31'h0, pausedOut}, 32'h1);
		chk(speedMilli[31:0], 32'h0);
		q = positionUu;
		repeat (50) @(posedge ref_clk);
		chk(positionUu, q);
		pin(4'h4);
		waitEnd(n0);
		chk(positionUu - p, 32'h1e);
		pin(4'h1);
		repeat (100) @(posedge ref_clk);
		pin(4'h2);
		chk({29'h0, busy, sequenceEndFlag, speedMilli != 48'h0}, 32'h0);
		wb(1'b1, 12'h000, 32'h6, q);
		pin(4'h1);
		chk({26'h0, currentIndex}, 32'h6);
		repeat (50) @(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		chk(positionUu, 32'h0);
		wb(1'b0, 12'h000, 32'h0, q);
		chk(q, 32'h0);
		close_out();
	end
endmodule : ims_sequencer_tb
`default_nettype wire
